// ==== hw/power_down_pkg.sv ====
// Purpose: Shared constants and types for the power reduction controller.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes:   Register byte address is four times the register index.

`default_nettype none

package power_down_pkg;

    // Bus geometry
    localparam int APB_AW = 12;

    // Register indices and byte addresses
    localparam logic [9:0]  PCTL_INDEX  = 10'h087;
    localparam logic [9:0]  WCFG_INDEX  = 10'h088;
    localparam logic [9:0]  WSTAT_INDEX = 10'h089;
    localparam logic [11:0] PCTL_ADDR   = {PCTL_INDEX, 2'b00};
    localparam logic [11:0] WCFG_ADDR   = {WCFG_INDEX, 2'b00};
    localparam logic [11:0] WSTAT_ADDR  = {WSTAT_INDEX, 2'b00};

    // power_control field positions
    localparam int IDLE_BIT    = 0;
    localparam int PD_BIT      = 1;
    localparam int GFA_BIT     = 2;
    localparam int GFB_BIT     = 3;
    localparam int SER_SEL_BIT = 6;
    localparam int DBL_BIT     = 7;

    // power_control reset value and writable bits
    localparam logic [7:0] PCTL_RESET  = 8'h00;
    localparam logic [7:0] PCTL_WRMASK = 8'hCF;

    // wake_config layout: external enables, keypad enables, keypad polarity
    localparam int         EXT_EN_LSB  = 0;
    localparam int         KEY_EN_LSB  = 2;
    localparam int         KEY_POL_LSB = 6;
    localparam logic [9:0] WCFG_RESET  = 10'h000;

    // Keypad wake settle count in clocks
    localparam int KEY_WAKE_CLOCKS = 1024;

    // Controller states, Gray along run, power-down, pin wake; keypad wake is two bits from power-down
    typedef enum logic [2:0] {
        ST_RUN      = 3'b000,
        ST_PDOWN    = 3'b001,
        ST_WAKE_IRQ = 3'b011,
        ST_WAKE_KEY = 3'b010,
        ST_IDLE     = 3'b100
    } pm_state_e;

    // Last wake source
    typedef enum logic [1:0] {
        WS_NONE = 2'h0,
        WS_EXT  = 2'h1,
        WS_KEY  = 2'h2
    } wake_src_e;

endpackage

`default_nettype wire

// ==== hw/power_down_control.sv ====
// Purpose: Idle and power-down sequencing with pin and keypad wake.
// Assumes: clk is an always-running reference; gated clocks are enables.
// Notes:   rst models the reset pin and resets every register asynchronously; clock enables load 1.
//
// Design decision made here: the APB register port.

`timescale 1ns/10ps
`default_nettype none

module power_down_control
    import power_down_pkg::*;
#(
    parameter int KeyWakeCount = KEY_WAKE_CLOCKS
) (
    input  wire logic              clk,               // Reference clock
    input  wire logic              rst,               // Reset pin, async
    input  wire logic              psel,              // APB select
    input  wire logic              penable,           // APB enable
    input  wire logic              pwrite,            // APB direction
    input  wire logic [APB_AW-1:0] paddr,             // APB byte address
    input  wire logic [31:0]       pwdata,            // APB write data
    output logic      [31:0]       prdata,            // APB read data
    output logic                   pready,            // APB ready
    output logic                   pslverr,           // APB error
    input  wire logic              irqPending,        // Core interrupt, idle exit
    input  wire logic [1:0]        extIrqN,           // Interrupt pins, low active
    input  wire logic [3:0]        keypadIn,          // Keypad wake pins
    input  wire logic              framingErrorFlag,  // Serial framing error
    input  wire logic              serialModeBitZero, // Serial mode bit zero
    output logic                   oscEnable,         // Oscillator run
    output logic                   cpuClkEnable,      // Processor clock gate
    output logic                   perClkEnable,      // Peripheral clock gate
    output logic                   wakeInterrupt,     // Wake service pulse
    output logic      [1:0]        wakeSource,        // Last wake source
    output logic                   serialDoubleRate,  // Baud doubler
    output logic                   serialSharedBit    // Selected serial bit
);

    localparam int CntW = $clog2(KeyWakeCount) + 1;

    typedef struct packed {
        pm_state_e       st;
        logic [7:0]      pctl;
        logic [9:0]      wcfg;
        logic [CntW-1:0] cnt;
        wake_src_e       src;
        logic [5:0]      pinMeta;
        logic [5:0]      pinSync;
        logic            osc;
        logic            cpuClk;
        logic            perClk;
        logic            wakeIrq;
        logic            sharedBit;
        logic [31:0]     rdata;
        logic            slvErr;
    } pm_regs_s;

    pm_regs_s   state_reg;
    pm_regs_s   state_next;
    logic [1:0] extLevel;
    logic [3:0] keyMatch;
    logic       extHit;
    logic       keyHit;
    logic       wrPctl;
    logic       wrWcfg;

    // Wake level qualification from synchronised pins
    always_comb begin
        extLevel = ~state_reg.pinSync[5:4];
        keyMatch = ~(state_reg.pinSync[3:0] ^ state_reg.wcfg[KEY_POL_LSB +: 4]);
        extHit   = |(extLevel & state_reg.wcfg[EXT_EN_LSB +: 2]);
        keyHit   = |(keyMatch & state_reg.wcfg[KEY_EN_LSB +: 4]);
        wrPctl   = psel && penable && pwrite && (paddr == PCTL_ADDR);
        wrWcfg   = psel && penable && pwrite && (paddr == WCFG_ADDR);
    end

    // Next state of the whole controller
    always_comb begin
        state_next         = state_reg;
        state_next.pinMeta = {extIrqN, keypadIn};
        state_next.pinSync = state_reg.pinMeta;
        state_next.wakeIrq = 1'b0;

        // Sequencer; hardware clears come before software writes
        case (state_reg.st)
            ST_IDLE: begin
                if (irqPending) begin
                    state_next.pctl[IDLE_BIT] = 1'b0;
                    state_next.st             = ST_RUN;
                end
            end
            ST_PDOWN: begin
                if (extHit) begin
                    state_next.pctl[PD_BIT]   = 1'b0;
                    state_next.pctl[IDLE_BIT] = 1'b0;
                    state_next.src            = WS_EXT;
                    state_next.st             = ST_WAKE_IRQ;
                end else if (keyHit) begin
                    state_next.pctl[PD_BIT]   = 1'b0;
                    state_next.pctl[IDLE_BIT] = 1'b0;
                    state_next.src            = WS_KEY;
                    state_next.cnt            = '0;
                    state_next.st             = ST_WAKE_KEY;
                end
            end
            ST_WAKE_IRQ: begin
                if (!extHit) begin
                    state_next.wakeIrq = 1'b1;
                    state_next.st      = ST_RUN;
                end
            end
            ST_WAKE_KEY: begin
                if (state_reg.cnt == CntW'(KeyWakeCount - 1)) begin
                    state_next.wakeIrq = 1'b1;
                    state_next.st      = ST_RUN;
                end else begin
                    state_next.cnt = state_reg.cnt + CntW'(1);
                end
            end
            default: begin
                state_next.st = ST_RUN;
            end
        endcase

        // Software writes win over a clear in the same cycle
        if (wrPctl) begin
            state_next.pctl = pwdata[7:0] & PCTL_WRMASK;
        end
        if (wrWcfg) begin
            state_next.wcfg = pwdata[9:0];
        end

        // Entry from run; power-down takes precedence over idle
        if (state_reg.st == ST_RUN) begin
            if (state_next.pctl[PD_BIT]) begin
                state_next.st = ST_PDOWN;
            end else if (state_next.pctl[IDLE_BIT]) begin
                state_next.st = ST_IDLE;
            end
        end

        // Clock gates follow the coming state; wake_config is not cleared on wake
        state_next.osc    = (state_next.st != ST_PDOWN);
        state_next.perClk = (state_next.st != ST_PDOWN);
        state_next.cpuClk = (state_next.st == ST_RUN);

        // Serial shared location select
        state_next.sharedBit = state_reg.pctl[SER_SEL_BIT] ? framingErrorFlag
                                                           : serialModeBitZero;

        // Read data and error captured in the setup phase
        if (psel && !penable) begin
            state_next.rdata  = 32'h0000_0000;
            state_next.slvErr = 1'b0;
            if (paddr == PCTL_ADDR) begin
                state_next.rdata[7:0] = state_reg.pctl;
            end else if (paddr == WCFG_ADDR) begin
                state_next.rdata[9:0] = state_reg.wcfg;
            end else if (paddr == WSTAT_ADDR) begin
                state_next.rdata[2:0] = state_reg.st;
                state_next.rdata[5:4] = state_reg.src;
                state_next.rdata[CntW+7:8] = state_reg.cnt;
            end else begin
                state_next.slvErr = 1'b1;
            end
        end
    end

    // State register; reset pin clears request bits and restarts clocks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg        <= '0;
            state_reg.st     <= ST_RUN;
            state_reg.pctl   <= PCTL_RESET;
            state_reg.wcfg   <= WCFG_RESET;
            state_reg.src    <= WS_NONE;
            state_reg.osc    <= 1'b1;
            state_reg.cpuClk <= 1'b1;
            state_reg.perClk <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs
    assign prdata           = state_reg.rdata;
    assign pready           = 1'b1;
    assign pslverr          = state_reg.slvErr;
    assign oscEnable        = state_reg.osc;
    assign cpuClkEnable     = state_reg.cpuClk;
    assign perClkEnable     = state_reg.perClk;
    assign wakeInterrupt    = state_reg.wakeIrq;
    assign wakeSource       = state_reg.src;
    assign serialDoubleRate = state_reg.pctl[DBL_BIT];
    assign serialSharedBit  = state_reg.sharedBit;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence pdWrite;
        wrPctl && pwdata[PD_BIT] && state_reg.st == ST_RUN;
    endsequence

    sequence keyWakeStart;
        state_reg.st == ST_PDOWN && keyHit && !extHit;
    endsequence

    sequence extWakeStart;
        state_reg.st == ST_PDOWN && extHit;
    endsequence

    a_pd_entry_now: assert property (pdWrite |=> state_reg.st == ST_PDOWN && !cpuClkEnable)
        else $error("power-down not entered at request");

    a_pd_clocks_off: assert property (state_reg.st == ST_PDOWN |->
        !oscEnable && !cpuClkEnable && !perClkEnable)
        else $error("clock running in power-down");

    a_pd_no_spurious: assert property (state_reg.st == ST_PDOWN && !extHit && !keyHit
        |=> state_reg.st == ST_PDOWN)
        else $error("power-down left without wake");

    a_wake_restart: assert property (extWakeStart |=> oscEnable && perClkEnable
        && !state_reg.pctl[PD_BIT] && !cpuClkEnable)
        else $error("interrupt wake restart wrong");

    a_irq_release_hold: assert property (state_reg.st == ST_WAKE_IRQ && extHit
        |=> !cpuClkEnable && !wakeInterrupt)
        else $error("processor resumed before pin release");

    a_key_count_run: assert property (keyWakeStart |=> state_reg.st == ST_WAKE_KEY
        && state_reg.cnt == '0 ##1 !cpuClkEnable [*7])
        else $error("keypad wake sequence wrong");

    a_key_count_end: assert property (state_reg.st == ST_WAKE_KEY
        && state_reg.cnt == CntW'(KeyWakeCount - 1) |=> cpuClkEnable && wakeInterrupt)
        else $error("keypad wake count end wrong");

    a_isr_first: assert property ($rose(cpuClkEnable) && $past(state_reg.st) != ST_IDLE
        |-> wakeInterrupt)
        else $error("resume without wake interrupt");

    a_pd_over_idle: assert property (pdWrite and wrPctl && pwdata[IDLE_BIT]
        |=> state_reg.st == ST_PDOWN ##1 state_reg.st != ST_IDLE)
        else $error("idle taken over power-down");

    a_idle_clocks: assert property (state_reg.st == ST_IDLE |->
        perClkEnable && oscEnable && !cpuClkEnable)
        else $error("idle clock gating wrong");

    a_idle_clear: assert property (state_reg.st == ST_IDLE && irqPending && !wrPctl
        |=> state_reg.st == ST_RUN && !state_reg.pctl[IDLE_BIT])
        else $error("idle request not cleared");

    // Wake timing summary for the checks below:
    // a pin level passes two synchroniser stages before extHit or keyHit
    // can see it, so every wake step is judged one edge after the
    // registered state that qualifies it. Software writes win over the
    // hardware clears, so checks that look at cleared bits exclude a
    // write in the same cycle. The keypad count is short in simulation,
    // which keeps the repetition counts small; the default count is
    // far longer and only its first eight cycles and its end point are checked there.

    a_ext_src: assert property (extWakeStart |=> wakeSource == WS_EXT)
        else $error("external wake source not recorded");

    a_key_src: assert property (keyWakeStart |=> wakeSource == WS_KEY)
        else $error("keypad wake source not recorded");

    a_release_resume: assert property (state_reg.st == ST_WAKE_IRQ && !extHit
        |=> state_reg.st == ST_RUN && cpuClkEnable && wakeInterrupt)
        else $error("no resume after pin release");

    a_wake_pulse_one: assert property (wakeInterrupt |=> !wakeInterrupt)
        else $error("wake interrupt longer than one cycle");

    a_pd_bits_clear: assert property (extWakeStart && !wrPctl
        |=> !state_reg.pctl[PD_BIT] && !state_reg.pctl[IDLE_BIT])
        else $error("request bits not cleared on wake");

    a_flags_write: assert property (wrPctl
        |=> state_reg.pctl == ($past(pwdata[7:0]) & PCTL_WRMASK))
        else $error("power control write not stored");

    a_reserved_zero: assert property (state_reg.pctl[5:4] == 2'b00)
        else $error("reserved bits stored");

    a_shared_select: assert property (1'b1 |=> serialSharedBit ==
        ($past(state_reg.pctl[SER_SEL_BIT]) ? $past(framingErrorFlag)
                                            : $past(serialModeBitZero)))
        else $error("shared serial bit wrong");

    a_run_clocks: assert property (state_reg.st == ST_RUN |->
        oscEnable && cpuClkEnable && perClkEnable)
        else $error("clock stopped in run");

    a_wake_keeps_cfg: assert property (extWakeStart && !wrWcfg
        |=> $stable(state_reg.wcfg))
        else $error("wake changed configuration");

endmodule

`default_nettype wire

// ==== testbench/wake_source_model.sv ====
// Purpose: Model of the wake sources: interrupt pins and keypad pins.
// Assumes: Requests come from the bench, changed just after a clock edge.
// Notes:   Pins are pure levels; a request holds its level until withdrawn.

`timescale 1ns/10ps
`default_nettype none

module wake_source_model (
    input  wire logic [1:0] extAssert,   // Pin asserted by the bench
    input  wire logic [3:0] keyPress,    // Key pressed by the bench
    input  wire logic [3:0] keyPolarity, // Active level of each key
    output logic      [1:0] extIrqN,     // Interrupt pins, low active
    output logic      [3:0] keypadIn     // Keypad pin levels
);
    // Interrupt pins: plain levels held as long as the bench asks
    assign extIrqN = ~extAssert;
    // Key pins show the active level while pressed, the inverse otherwise
    assign keypadIn = keyPress ~^ keyPolarity;
endmodule

`default_nettype wire

// ==== testbench/tb.sv ====
// Purpose: Self-checking bench for the power reduction controller.
// Assumes: APB answers without wait states; keypad count shortened to 8.
// Notes:   Tests are sequences of APB calls and pin events.

`timescale 1ns/10ps
`default_nettype none

module tb;
    import power_down_pkg::*;
    localparam int Kwc = 8;
    logic        clk, rst, psel, penable, pwrite, irqPending, framingErrorFlag;
    logic        serialModeBitZero, pready, pslverr, oscEnable, cpuClkEnable;
    logic        perClkEnable, wakeInterrupt, serialDoubleRate, serialSharedBit;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  extIrqN, wakeSource, extAssert;
    logic [3:0]  keypadIn, keyPress, keyPolarity;
    logic        err;
    int          n_errors, cmp_count, n;

    power_down_control #(.KeyWakeCount(Kwc)) DUT (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irqPending(irqPending), .extIrqN(extIrqN),
        .keypadIn(keypadIn), .framingErrorFlag(framingErrorFlag),
        .serialModeBitZero(serialModeBitZero), .oscEnable(oscEnable),
        .cpuClkEnable(cpuClkEnable), .perClkEnable(perClkEnable),
        .wakeInterrupt(wakeInterrupt), .wakeSource(wakeSource),
        .serialDoubleRate(serialDoubleRate), .serialSharedBit(serialSharedBit));

    wake_source_model pins (.extAssert(extAssert), .keyPress(keyPress),
        .keyPolarity(keyPolarity), .extIrqN(extIrqN), .keypadIn(keypadIn));

    // Clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Wait for oscillator (sel 0) or processor clock (sel 1) to run; n counts edges
    task automatic waitOn(input logic sel);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((sel ? cpuClkEnable : oscEnable) !== 1'b1 && n < 2000);
        check("wake wait", 32'(n < 2000), 32'h1);
    endtask

    task automatic cycles(input int k);
        repeat (k) @(posedge clk);
    endtask

    // Verdict and end of run
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog
    initial begin
        #400000;
        n_errors++;
        end_sim();
    end

    // Main sequence
    initial begin
        n_errors = 0; cmp_count = 0; rst = 1'b1; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; irqPending = 1'b0;
        framingErrorFlag = 1'b1; serialModeBitZero = 1'b0;
        extAssert = 2'b00; keyPress = 4'h0; keyPolarity = 4'h0;
        cycles(20);
        rst <= 1'b0;
        apb(1'b0, PCTL_ADDR, 32'h0);
        check("pctl reset", rd, 32'h0000_0000);
        apb(1'b0, 12'hFF0, 32'h0);
        check("unmapped err", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
        $display("test reset and map done");
        // Flags and serial controls, reserved bits left zero
        apb(1'b1, PCTL_ADDR, 32'h0000_00CC);
        apb(1'b0, PCTL_ADDR, 32'h0);
        check("pctl flags", rd, 32'h0000_00CC);
        cycles(2);
        check("double rate", 32'(serialDoubleRate), 32'h1);
        check("shared bit fe", 32'(serialSharedBit), 32'h1);
        apb(1'b1, PCTL_ADDR, 32'h0000_008C);
        cycles(2);
        check("shared bit sm0", 32'(serialSharedBit), 32'h0);
        $display("test register fields done");
        // Idle: processor stops, peripherals run, interrupt exits
        apb(1'b1, PCTL_ADDR, 32'h0000_00CD);
        cycles(2);
        check("idle cpu", 32'(cpuClkEnable), 32'h0);
        check("idle per", 32'(perClkEnable), 32'h1);
        irqPending <= 1'b1;
        waitOn(1'b1);
        irqPending <= 1'b0;
        apb(1'b0, PCTL_ADDR, 32'h0);
        check("idle cleared", rd, 32'h0000_00CC);
        $display("test idle done");
        // Power-down with idle too, pin wake
        apb(1'b1, WCFG_ADDR, 32'h0000_0001);
        apb(1'b1, PCTL_ADDR, 32'h0000_00CF);
        cycles(2);
        check("pd osc", 32'(oscEnable), 32'h0);
        check("pd cpu", 32'(cpuClkEnable), 32'h0);
        check("pd per", 32'(perClkEnable), 32'h0);
        extAssert <= 2'b10;
        irqPending <= 1'b1;
        cycles(12);
        check("disabled pin", 32'(oscEnable), 32'h0);
        extAssert <= 2'b01;
        irqPending <= 1'b0;
        waitOn(1'b0);
        cycles(20);
        check("held pin per", 32'(perClkEnable), 32'h1);
        check("held pin cpu", 32'(cpuClkEnable), 32'h0);
        extAssert <= 2'b00;
        waitOn(1'b1);
        check("pin wake irq", 32'(wakeInterrupt), 32'h1);
        @(negedge clk);
        check("irq pulse", 32'(wakeInterrupt), 32'h0);
        check("pin source", 32'(wakeSource), 32'h1);
        cycles(4);
        check("no idle after", 32'(cpuClkEnable), 32'h1);
        apb(1'b0, PCTL_ADDR, 32'h0);
        check("pd cleared", rd, 32'h0000_00CC);
        $display("test pin wake done");
        // Keypad wake on low level, key held through the count
        apb(1'b1, WCFG_ADDR, 32'h0000_0020);
        apb(1'b1, PCTL_ADDR, 32'h0000_0002);
        cycles(3);
        keyPress <= 4'h8;
        waitOn(1'b0);
        waitOn(1'b1);
        check("key count", 32'(n >= Kwc - 1 && n <= Kwc + 1), 32'h1);
        check("key irq", 32'(wakeInterrupt), 32'h1);
        check("key source", 32'(wakeSource), 32'h2);
        keyPress <= 4'h0;
        apb(1'b0, PCTL_ADDR, 32'h0);
        check("key pd cleared", rd, 32'h0);
        $display("test keypad wake done");
        // Reset pin during power-down
        apb(1'b1, PCTL_ADDR, 32'h0000_00CE);
        cycles(3);
        check("pd again", 32'(oscEnable), 32'h0);
        rst <= 1'b1;
        #2;
        check("rst osc", 32'(oscEnable), 32'h1);
        check("rst cpu", 32'(cpuClkEnable), 32'h1);
        cycles(3);
        rst <= 1'b0;
        apb(1'b0, PCTL_ADDR, 32'h0);
        check("rst pctl", rd, 32'h0);
        apb(1'b0, WCFG_ADDR, 32'h0);
        check("rst wcfg", rd, 32'h0);
        $display("test reset wake done");
        end_sim();
    end
endmodule

`default_nettype wire
